// file: core/rel_rx_error_log.sv
// Purpose: receive link error log, interrupt gating and reinit request.
// Assumes: lane event inputs are one-cycle pulses synchronous to clk.
// Notes: interrupt and sync request follow the flags one cycle later.
//
// Notes on behaviour
// - irq when flag set and enabled
// - reinit request for flags with reinit enable
// - code group error always forces reinit
// - bit 9 on uncorrectable memory error
// - bit 8 on corrected memory error
// - bit 6 when K run lacks alignment sequence
// - bit 5 on wrong disparity column
// - bit 4 on code not in table
// - bit 3 on unexpected control character
// - misplaced A or F not counted as bit 3
// - bit 2 on misplaced multiframe end marker
// - bit 1 on misplaced frame end marker
// - no on-the-fly realignment after misalignment
// - bit 0 when sync machine reenters init
// - disabled enable still logs the flag
// - enable bits 20 to 11 mirror flags
// - irq enables reset to one except bit 19; of the reinit enables only bit 11 resets to one
// - flags reset zero, upper bits read zero
// - reinit requested by driving sync low
//
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/1ps
module rel_rx_error_log
   import rel_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input rel_lane_evt_t [NUM_LANES-1:0] laneEvt,
   input wire logic eccSingleEvt,
   input wire logic eccDoubleEvt,
   input wire logic linkSpareEvt,
   output logic irq,
   output logic syncN,
   output logic alignFrozen
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [31:0] irqEn;
      logic [31:0] reinitEn;
      logic irq;
      logic syncN;
      logic alignFrozen;
   } rel_main_state_t;

   rel_main_state_t state_r;
   rel_main_state_t state_nxt;

   rel_reg_wr_t regWr;
   logic [31:0] rdAddr;
   logic [31:0] rdValue;
   logic [STATUS_W-1:0] setVec;
   logic [STATUS_W-1:0] clrVec;
   logic [STATUS_W-1:0] flags;
   logic [STATUS_W-1:0] laneSet [NUM_LANES];
   logic [STATUS_W-1:0] irqEnFlags;
   logic [STATUS_W-1:0] reinitEnFlags;

   // ----------------------------------------------------------------
   // lane event decode
   // ----------------------------------------------------------------
   function automatic logic [STATUS_W-1:0] laneDecode(input rel_lane_evt_t e);
      logic [STATUS_W-1:0] v;
      v = '0;
      v[ST_NOT_IN_TABLE] = e.codeValid & ~e.tableHit;
      v[ST_DISPARITY] = e.codeValid & e.tableHit & ~e.columnOk;
      // A and F markers are judged by position, never as stray controls
      v[ST_CTRL_CHAR] = e.ctrlChar & ~e.ctrlExpected & ~e.isA & ~e.isF;
      v[ST_LANE_ALIGN] = e.ctrlChar & e.isA & ~e.atMfEnd;
      v[ST_FRAME_ALIGN] = e.ctrlChar & (e.isF | e.isA) & ~e.atFrameEnd;
      v[ST_MISSING_ILAS] = e.kRunEnd & ~e.ilasFollows;
      v[ST_CGS] = e.cgsInit;
      return v;
   endfunction : laneDecode

   for (genvar l = 0; l < NUM_LANES; l++) begin : g_lane
      assign laneSet[l] = laneDecode(laneEvt[l]);
   end

   always_comb begin
      setVec = '0;
      for (int l = 0; l < NUM_LANES; l++) begin
         setVec = setVec | laneSet[l];
      end
      setVec[ST_ECC_FATAL] = eccDoubleEvt;
      setVec[ST_ECC_CORR] = eccSingleEvt;
      setVec[ST_SPARE] = linkSpareEvt;
   end

   // ----------------------------------------------------------------
   // register access
   // ----------------------------------------------------------------
   function automatic logic isWrTo(input rel_reg_wr_t w, input logic [31:0] ofs);
      return w.en && (w.addr == ofs);
   endfunction : isWrTo

   assign clrVec = isWrTo(regWr, OFS_STATUS_B) ? regWr.data[STATUS_W-1:0] : '0;

   always_comb begin
      rdValue = RDATA_ZERO;
      case (rdAddr)
         OFS_STATUS_B: rdValue[STATUS_W-1:0] = flags;
         OFS_IRQ_EN: rdValue = state_r.irqEn;
         OFS_REINIT_EN: rdValue = state_r.reinitEn;
         OFS_LINK_STATE: rdValue[2:0] = {state_r.alignFrozen, state_r.syncN, state_r.irq};
         default: rdValue = RDATA_ZERO;
      endcase
   end

   rel_ahb_slave u_bus (
      .clk(clk),
      .sys_rst(sys_rst),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hwdata(hwdata),
      .hready(hready),
      .hrdata(hrdata),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .regWr(regWr),
      .rdAddr(rdAddr),
      .rdValue(rdValue)
   );

   rel_sticky_flags u_flags (
      .clk(clk),
      .sys_rst(sys_rst),
      .setVec(setVec),
      .clrVec(clrVec),
      .flags(flags)
   );

   // ----------------------------------------------------------------
   // interrupt and reinit gating
   // ----------------------------------------------------------------
   // enable bit n+11 belongs to flag bit n
   assign irqEnFlags = state_r.irqEn[EN_HI:EN_LO];
   assign reinitEnFlags = state_r.reinitEn[EN_HI:EN_LO];

   always_comb begin
      state_nxt = state_r;
      if (isWrTo(regWr, OFS_IRQ_EN)) begin
         state_nxt.irqEn = regWr.data & EN_WR_MASK;
      end
      if (isWrTo(regWr, OFS_REINIT_EN)) begin
         state_nxt.reinitEn = regWr.data & EN_WR_MASK;
      end
      state_nxt.irq = |(flags & irqEnFlags);
      // code group loss bypasses its enable so the link always resyncs
      state_nxt.syncN = ~(flags[ST_CGS] | (|(flags & reinitEnFlags)));
      // alignment is never repaired in place; only a fresh sync releases it
      if (setVec[ST_CGS]) begin
         state_nxt.alignFrozen = 1'b0;
      end
      if (setVec[ST_LANE_ALIGN] | setVec[ST_FRAME_ALIGN]) begin
         state_nxt.alignFrozen = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_r.irqEn <= IRQ_EN_RESET;
         state_r.reinitEn <= REINIT_EN_RESET;
         state_r.irq <= 1'b0;
         state_r.syncN <= 1'b1;
         state_r.alignFrozen <= 1'b0;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign irq = state_r.irq;
   assign syncN = state_r.syncN;
   assign alignFrozen = state_r.alignFrozen;

endmodule : rel_rx_error_log

// file: core/rel_pkg.sv
// Purpose: shared constants and carrier types of the receive error log block.
// Assumes: 32-bit AHB-Lite register access, one 40 MHz clock.
// Notes: all offsets are byte addresses of aligned words.
package rel_pkg;

   // ----------------------------------------------------------------
   // geometry
   // ----------------------------------------------------------------
   localparam int NUM_LANES = 4;
   localparam int STATUS_W = 10;
   localparam int EN_SHIFT = 11;
   localparam int EN_LO = 11;
   localparam int EN_HI = 20;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [31:0] OFS_STATUS_B = 32'h0000_0064;
   localparam logic [31:0] OFS_IRQ_EN = 32'h0000_0074;
   localparam logic [31:0] OFS_REINIT_EN = 32'h0000_0078;
   localparam logic [31:0] OFS_LINK_STATE = 32'h0000_007C;

   // ----------------------------------------------------------------
   // status bit positions
   // ----------------------------------------------------------------
   localparam int ST_CGS = 0;
   localparam int ST_FRAME_ALIGN = 1;
   localparam int ST_LANE_ALIGN = 2;
   localparam int ST_CTRL_CHAR = 3;
   localparam int ST_NOT_IN_TABLE = 4;
   localparam int ST_DISPARITY = 5;
   localparam int ST_MISSING_ILAS = 6;
   localparam int ST_SPARE = 7;
   localparam int ST_ECC_CORR = 8;
   localparam int ST_ECC_FATAL = 9;

   // ----------------------------------------------------------------
   // reset values and writable masks
   // ----------------------------------------------------------------
   localparam logic [STATUS_W-1:0] STATUS_RESET = 10'h000;
   localparam logic [31:0] IRQ_EN_RESET = 32'h0017_F9FE;
   localparam logic [31:0] REINIT_EN_RESET = 32'h0000_0902;
   localparam logic [31:0] EN_WR_MASK = 32'h001F_F9FE;
   localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   // per-lane observations from the lane decoders, each a one-cycle pulse
   typedef struct packed {
      logic codeValid;
      logic tableHit;
      logic columnOk;
      logic ctrlChar;
      logic ctrlExpected;
      logic isA;
      logic isF;
      logic atFrameEnd;
      logic atMfEnd;
      logic kRunEnd;
      logic ilasFollows;
      logic cgsInit;
   } rel_lane_evt_t;

   typedef struct packed {
      logic en;
      logic [31:0] addr;
      logic [31:0] data;
   } rel_reg_wr_t;

endpackage : rel_pkg

// file: core/rel_ahb_slave.sv
// Purpose: AHB-Lite slave front end for the error log registers.
// Assumes: single word transfers; the only slave on its bus.
// Notes: writes take no wait state, reads take one so they see prior writes.
`timescale 1ns/1ps
module rel_ahb_slave
   import rel_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output rel_reg_wr_t regWr,
   output logic [31:0] rdAddr,
   input wire logic [31:0] rdValue
);

   typedef struct packed {
      logic pendWr;
      logic pendRd;
      logic [31:0] addr;
      logic [31:0] rdata;
      logic readyOut;
   } rel_ahb_state_t;

   rel_ahb_state_t state_r;
   rel_ahb_state_t state_nxt;
   logic unusedSize;

   assign unusedSize = ^hsize;

   // ----------------------------------------------------------------
   // transfer sequencing
   // ----------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;
      state_nxt.pendWr = 1'b0;
      if (state_r.pendRd) begin
         state_nxt.rdata = rdValue;
         state_nxt.readyOut = 1'b1;
         state_nxt.pendRd = 1'b0;
      end
      if (hsel && hready && htrans[1]) begin
         state_nxt.addr = haddr;
         state_nxt.pendWr = hwrite;
         state_nxt.pendRd = !hwrite;
         state_nxt.readyOut = hwrite;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_r <= '{pendWr: 1'b0, pendRd: 1'b0, addr: RDATA_ZERO,
                      rdata: RDATA_ZERO, readyOut: 1'b1};
      end else begin
         state_r <= state_nxt;
      end
   end

   assign hrdata = state_r.rdata;
   assign hreadyout = state_r.readyOut;
   assign hresp = 1'b0;
   assign rdAddr = state_r.addr;
   assign regWr = '{en: state_r.pendWr, addr: state_r.addr, data: hwdata};

endmodule : rel_ahb_slave

// file: core/rel_sticky_flags.sv
// Purpose: bank of sticky status flags, set by hardware, cleared by writing one.
// Assumes: set and clear are one-cycle pulses.
// Notes: a set in the clearing cycle survives.
`timescale 1ns/1ps
module rel_sticky_flags
   import rel_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [STATUS_W-1:0] setVec,
   input wire logic [STATUS_W-1:0] clrVec,
   output logic [STATUS_W-1:0] flags
);

   typedef struct packed {
      logic [STATUS_W-1:0] flag;
   } rel_flag_state_t;

   rel_flag_state_t state_r;
   rel_flag_state_t state_nxt;

   // ----------------------------------------------------------------
   // per-bit set / clear
   // ----------------------------------------------------------------
   for (genvar i = 0; i < STATUS_W; i++) begin : g_flag
      always_comb begin
         state_nxt.flag[i] = setVec[i] | (state_r.flag[i] & ~clrVec[i]);
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_r.flag <= STATUS_RESET;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign flags = state_r.flag;

endmodule : rel_sticky_flags

// file: bench/rel_rx_error_log_chk.sv
// Purpose: timing checks on the error log ports.
// Assumes: hready is the slave's own hreadyout.
// Notes: a write lands two edges after its address, outputs follow one edge later.
`timescale 1ns/1ps
module rel_rx_error_log_chk
   import rel_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input rel_lane_evt_t [NUM_LANES-1:0] laneEvt,
   input wire logic eccSingleEvt,
   input wire logic eccDoubleEvt,
   input wire logic linkSpareEvt,
   input wire logic irq,
   input wire logic syncN,
   input wire logic alignFrozen
);
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   logic rdTake, wrTake, anyEvt, cgsAny, misAlign;
   assign rdTake = hsel & hready & htrans[1] & ~hwrite;
   assign wrTake = hsel & hready & htrans[1] & hwrite;
   assign anyEvt = (|laneEvt) | eccSingleEvt | eccDoubleEvt | linkSpareEvt;
   always_comb begin
      cgsAny = 1'b0;
      misAlign = 1'b0;
      for (int i = 0; i < NUM_LANES; i++) begin
         cgsAny = cgsAny | laneEvt[i].cgsInit;
         misAlign = misAlign | (laneEvt[i].ctrlChar & ((laneEvt[i].isA & ~laneEvt[i].atMfEnd)
            | ((laneEvt[i].isA | laneEvt[i].isF) & ~laneEvt[i].atFrameEnd)));
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   sequence readWait;
      !hreadyout ##1 hreadyout;
   endsequence
   a_read_one_wait: assert property (rdTake |=> readWait)
      else $error("read wait state wrong");
   a_write_no_wait: assert property (wrTake |=> hreadyout)
      else $error("write stalled");
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("response not okay");
   a_rdata_hold: assert property ($changed(hrdata) |-> $past(rdTake, 2))
      else $error("read data moved without a read");
   a_cgs_forces_sync: assert property (cgsAny |-> ##2 !syncN)
      else $error("sync request missing after code group loss");
   a_sync_release: assert property ($rose(syncN) |-> $past(wrTake, 3))
      else $error("sync request dropped without a write");
   a_irq_drop: assert property ($fell(irq) |-> $past(wrTake, 3))
      else $error("irq dropped without a write");
   a_irq_cause: assert property ($rose(irq) |-> $past(anyEvt, 2) || $past(wrTake, 3))
      else $error("irq without cause");
   a_frozen_set: assert property (misAlign |-> ##[1:2] alignFrozen)
      else $error("misalignment not frozen");
   a_frozen_hold: assert property (alignFrozen && !cgsAny && !$past(cgsAny) |=> alignFrozen)
      else $error("realigned without restart");
endmodule : rel_rx_error_log_chk
bind rel_rx_error_log rel_rx_error_log_chk rel_rx_error_log_chk_inst (.*);

// file: bench/rx_link_error_log_irq_bench.sv
// Purpose: self-checking bench for the receive error log.
// Assumes: hready fed back from hreadyout, one slave.
// Notes: outputs are checked a fixed three edges after an event pulse.
`timescale 1ns/1ps
module rx_link_error_log_irq_bench;
   import rel_pkg::*;
   logic clk = 1'b0, sysRst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic hreadyout, hresp, irq, syncN, alignFrozen;
   logic eccS = 1'b0, eccD = 1'b0, spare = 1'b0, fz = 1'b0;
   rel_lane_evt_t [NUM_LANES-1:0] laneEvt = '0;
   int nFail = 0, samplesChecked = 0, cyc = 0;
   logic [31:0] seed = 32'h0001_7D8D;
   always #12.5 clk = ~clk;
   rel_rx_error_log rel_rx_error_log_inst (.clk(clk), .sys_rst(sysRst), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .laneEvt(laneEvt), .eccSingleEvt(eccS), .eccDoubleEvt(eccD), .linkSpareEvt(spare),
      .irq(irq), .syncN(syncN), .alignFrozen(alignFrozen));
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] xrand();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xrand
   // 10 and up are legal markers or codes: they must log nothing
   function automatic rel_lane_evt_t evt_for(int b);
      rel_lane_evt_t e;
      e = '0;
      case (b)
         0: e.cgsInit = 1'b1;
         1: begin e.ctrlChar = 1'b1; e.isF = 1'b1; e.atMfEnd = 1'b1; end
         2: begin e.ctrlChar = 1'b1; e.isA = 1'b1; e.atFrameEnd = 1'b1; end
         3: e.ctrlChar = 1'b1;
         4: e.codeValid = 1'b1;
         5: begin e.codeValid = 1'b1; e.tableHit = 1'b1; end
         6: e.kRunEnd = 1'b1;
         10: begin e.ctrlChar = 1'b1; e.isA = 1'b1; e.atMfEnd = 1'b1; e.atFrameEnd = 1'b1; end
         11: begin e.codeValid = 1'b1; e.tableHit = 1'b1; e.columnOk = 1'b1; end
         12: begin e.ctrlChar = 1'b1; e.ctrlExpected = 1'b1; end
         13: begin e.kRunEnd = 1'b1; e.ilasFollows = 1'b1; end
         default: e = '0;
      endcase
      return e;
   endfunction : evt_for
   function automatic logic [31:0] exp_st(int b);
      return (b < STATUS_W) ? (32'h1 << b) : 32'h0;
   endfunction : exp_st
   function automatic logic [2:0] exp_out(int b, logic [31:0] en, logic [31:0] re, logic f);
      logic hit;
      hit = b < STATUS_W;
      return {hit && en[b + EN_SHIFT], !(b == ST_CGS || (hit && re[b + EN_SHIFT])), f};
   endfunction : exp_out
   task automatic check(string name, logic [31:0] exp, logic [31:0] got);
      samplesChecked++;
      if (got !== exp) begin
         nFail++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask : check
   task automatic wait_rdy();
      do @(posedge clk); while (hreadyout !== 1'b1);
   endtask : wait_rdy
   task automatic bus(logic wr, logic [31:0] a, logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= wr;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      q = hrdata;
   endtask : bus
   task automatic fire(int b);
      @(posedge clk);
      laneEvt[xrand() % NUM_LANES] <= evt_for(b);
      eccS <= (b == ST_ECC_CORR);
      eccD <= (b == ST_ECC_FATAL);
      spare <= (b == ST_SPARE);
      @(posedge clk);
      laneEvt <= '0;
      eccS <= 1'b0;
      eccD <= 1'b0;
      spare <= 1'b0;
      repeat (2) @(posedge clk);
      if (b == ST_CGS) fz = 1'b0;
      if (b == ST_FRAME_ALIGN || b == ST_LANE_ALIGN) fz = 1'b1;
   endtask : fire
   task automatic finalReport();
      $display("comparisons %0d mismatches %0d", samplesChecked, nFail);
      if (nFail == 0 && samplesChecked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : finalReport
   always @(posedge clk) begin
      cyc++;
      if (cyc > 20000) begin
         nFail++;
         finalReport();
      end
   end
   // ----------------------------------------------------------------
   // sequence
   // ----------------------------------------------------------------
   initial begin
      logic [31:0] q, en, re;
      logic [2:0] o;
      int b;
      en = EN_WR_MASK & ~32'h0008_0000;
      re = REINIT_EN_RESET;
      repeat (4) @(posedge clk);
      sysRst <= 1'b0;
      bus(1'b0, OFS_STATUS_B, 32'h0, q);
      check("status reset", 32'h0, q);
      bus(1'b0, OFS_IRQ_EN, 32'h0, q);
      check("irq enable reset", en, q);
      bus(1'b0, OFS_REINIT_EN, 32'h0, q);
      check("reinit enable reset", REINIT_EN_RESET, q);
      bus(1'b1, 32'h0000_0080, 32'hFFFF_FFFF, q);
      bus(1'b0, 32'h0000_0080, 32'h0, q);
      check("unmapped", 32'h0, q);
      for (b = 0; b <= 13; b++) begin
         fire(b);
         check("outputs", exp_out(b, en, re, fz), {irq, syncN, alignFrozen});
         bus(1'b1, OFS_STATUS_B, 32'h0, q);
         bus(1'b0, OFS_STATUS_B, 32'h0, q);
         check("status set", exp_st(b), q);
         bus(1'b1, OFS_STATUS_B, exp_st(b), q);
         bus(1'b0, OFS_STATUS_B, 32'h0, q);
         check("status cleared", 32'h0, q);
      end
      // software masks the missing sequence error: flag logged, no irq
      en = en & ~32'h0002_0000;
      bus(1'b1, OFS_IRQ_EN, en, q);
      fire(ST_MISSING_ILAS);
      o = exp_out(ST_MISSING_ILAS, en, re, fz);
      check("masked sequence error", o, {irq, syncN, alignFrozen});
      bus(1'b0, OFS_STATUS_B, 32'h0, q);
      check("masked flag logged", exp_st(ST_MISSING_ILAS), q);
      bus(1'b1, OFS_STATUS_B, exp_st(ST_MISSING_ILAS), q);
      bus(1'b0, OFS_STATUS_B, 32'h0, q);
      check("masked flag cleared", 32'h0, q);
      for (int i = 0; i < 10; i++) begin
         en = xrand();
         re = xrand() & ~((i == 0) ? 32'h800 : 32'h0);
         b = (i == 0) ? ST_CGS : int'(xrand() % STATUS_W);
         bus(1'b1, OFS_IRQ_EN, en, q);
         bus(1'b1, OFS_REINIT_EN, re, q);
         bus(1'b0, OFS_IRQ_EN, 32'h0, q);
         check("irq enable", en & EN_WR_MASK, q);
         bus(1'b0, OFS_REINIT_EN, 32'h0, q);
         check("reinit enable", re & EN_WR_MASK, q);
         fire(b);
         o = exp_out(b, en, re, fz);
         check("outputs", o, {irq, syncN, alignFrozen});
         bus(1'b0, OFS_LINK_STATE, 32'h0, q);
         check("link state", {29'h0, o[0], o[1], o[2]}, q);
         bus(1'b1, OFS_STATUS_B, exp_st(b), q);
      end
      finalReport();
   end
endmodule : rx_link_error_log_irq_bench
